// ==== fpsc_ctrl.v ====
// Flash programming controller: command interpreter, security flags, pin hold.
// Assumes a UART receiver/transmitter on sys_clk that moves whole bytes.
`timescale 1ns/100ps
`default_nettype none
`include "fpsc_map.vh"

module fpsc_ctrl (
  input  wire                sys_clk,
  input  wire                rst_n,
  input  wire                prog_attach,
  input  wire                rx_valid,
  input  wire [7:0]          rx_data,
  output reg                 resp_valid,
  output reg  [7:0]          resp_code,
  output reg  [15:0]         resp_sum,
  output reg                 prog_mode,
  input  wire                self_mode,
  input  wire                self_cmd_valid,
  input  wire [1:0]          self_op,
  input  wire [`FPSC_AW-1:0] self_addr,
  input  wire [7:0]          self_data,
  output wire                self_busy,
  output reg                 self_done,
  output reg                 self_ok,
  input  wire [7:0]          user_port_out,
  input  wire [7:0]          user_port_oe,
  output reg  [7:0]          port_out,
  output reg  [7:0]          port_oe,
  output reg  [2:0]          sec_active
);

  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_PARAM = 9'h002;
  localparam [8:0] ST_DISP  = 9'h004;
  localparam [8:0] ST_ERASE = 9'h008;
  localparam [8:0] ST_WDATA = 9'h010;
  localparam [8:0] ST_WPROG = 9'h020;
  localparam [8:0] ST_VER   = 9'h040;
  localparam [8:0] ST_SUM   = 9'h080;
  localparam [8:0] ST_BLANK = 9'h100;

  reg [8:0]          state;
  reg [`FPSC_AW-1:0] addr;
  reg [`FPSC_AW-1:0] end_addr;
  reg [15:0]         sum;
  reg                err;
  reg [7:0]          cmd;
  reg [31:0]         par;
  reg [2:0]          pcnt;
  reg [7:0]          wbyte;
  reg                src_self;
  reg [2:0]          sec_store;
  reg                attach_meta;
  reg                attach_s;

  wire [7:0]          rd_data;
  wire [`FPSC_AW-1:0] range_lo;
  wire [`FPSC_AW-1:0] range_hi;
  wire                range_bad;
  wire                last;

  function known_cmd;
    input [7:0] c;
    begin
      known_cmd = (c == `FPSC_CMD_CHIP) || (c == `FPSC_CMD_BLOCK) ||
                  (c == `FPSC_CMD_BLANK) || (c == `FPSC_CMD_WRITE) ||
                  (c == `FPSC_CMD_SEC) || (c == `FPSC_CMD_SUM);
    end
  endfunction

  function [2:0] param_count;
    input [7:0] c;
    begin
      if ((c == `FPSC_CMD_WRITE) || (c == `FPSC_CMD_SUM))
        param_count = `FPSC_PCNT_FOUR;
      else if ((c == `FPSC_CMD_BLOCK) || (c == `FPSC_CMD_SEC))
        param_count = `FPSC_PCNT_ONE;
      else
        param_count = `FPSC_PCNT_ZERO;
    end
  endfunction

  assign range_lo  = par[27:16];
  assign range_hi  = par[11:0];
  assign range_bad = range_hi < range_lo;
  assign last      = addr == end_addr;
  assign self_busy = src_self;

  fpsc_flash u_flash (
    .sys_clk (sys_clk),
    .wr_en   ((state == ST_ERASE) || (state == ST_WPROG)),
    .erase   (state == ST_ERASE),
    .addr    (addr),
    .wr_data (wbyte),
    .rd_data (rd_data)
  );

  // Attach comes from a pin, so it is synchronised first
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      attach_meta <= 1'b0;
      attach_s    <= 1'b0;
    end else begin
      attach_meta <= prog_attach;
      attach_s    <= attach_meta;
    end
  end

  // Pins are registered so a mode change never glitches them
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out <= `FPSC_PORT_RST_OUT;
      port_oe  <= `FPSC_PORT_RST_OE;
    end else if (prog_mode) begin
      port_out <= `FPSC_PORT_RST_OUT;
      port_oe  <= `FPSC_PORT_RST_OE;
    end else if (!self_mode) begin
      port_out <= user_port_out;
      port_oe  <= user_port_oe;
    end
    // Self programming leaves the pins frozen as in halt
  end

  task finish;
    input ok;
    begin
      state <= ST_IDLE;
      if (src_self) begin
        src_self  <= 1'b0;
        self_done <= 1'b1;
        self_ok   <= ok;
      end else begin
        resp_valid <= 1'b1;
        resp_code  <= ok ? `FPSC_RESP_ACK : `FPSC_RESP_NAK;
      end
    end
  endtask

  task start_block;
    input [3:0] blk;
    begin
      addr     <= {blk, `FPSC_BLK_FIRST};
      end_addr <= {blk, `FPSC_BLK_LAST};
    end
  endtask

  // Only the programmer's reset reaches rst_n while in programming mode
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      addr       <= `FPSC_ADDR_ZERO;
      end_addr   <= `FPSC_ADDR_ZERO;
      sum        <= `FPSC_SUM_ZERO;
      err        <= 1'b0;
      cmd        <= `FPSC_BLK_FIRST;
      par        <= `FPSC_PAR_ZERO;
      pcnt       <= `FPSC_PCNT_ZERO;
      wbyte      <= `FPSC_BLANK_BYTE;
      src_self   <= 1'b0;
      sec_store  <= `FPSC_SEC_NONE;
      sec_active <= `FPSC_SEC_NONE;
      prog_mode  <= 1'b0;
      resp_valid <= 1'b0;
      resp_code  <= `FPSC_RESP_NAK;
      resp_sum   <= `FPSC_SUM_ZERO;
      self_done  <= 1'b0;
      self_ok    <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      self_done  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (!attach_s && prog_mode) begin
            prog_mode <= 1'b0;
          end else if (self_mode && !prog_mode && self_cmd_valid) begin
            // Security flags are never consulted on this path
            src_self <= 1'b1;
            err      <= 1'b0;
            case (self_op)
              `FPSC_SELF_ERASE: begin
                start_block(self_addr[11:8]);
                state <= ST_ERASE;
              end
              `FPSC_SELF_BLANK: begin
                start_block(self_addr[11:8]);
                state <= ST_BLANK;
              end
              `FPSC_SELF_WRITE: begin
                addr     <= self_addr;
                end_addr <= self_addr;
                wbyte    <= self_data;
                state    <= ST_WPROG;
              end
              default: begin
                src_self  <= 1'b0;
                self_done <= 1'b1;
                self_ok   <= 1'b0;
              end
            endcase
          end else if (rx_valid && attach_s && (prog_mode || known_cmd(rx_data))) begin
            cmd       <= rx_data;
            prog_mode <= 1'b1;
            if (!prog_mode)
              sec_active <= sec_store;
            pcnt <= `FPSC_PCNT_ZERO;
            if (!known_cmd(rx_data))
              finish(1'b0);
            else if (param_count(rx_data) != `FPSC_PCNT_ZERO)
              state <= ST_PARAM;
            else
              state <= ST_DISP;
          end
        end
        ST_PARAM: begin
          if (rx_valid) begin
            par  <= {par[23:0], rx_data};
            pcnt <= pcnt + `FPSC_PCNT_ONE;
            if (pcnt + `FPSC_PCNT_ONE == param_count(cmd))
              state <= ST_DISP;
          end
        end
        ST_DISP: begin
          err <= 1'b0;
          sum <= `FPSC_SUM_ZERO;
          case (cmd)
            `FPSC_CMD_CHIP: begin
              if (sec_active[`FPSC_SEC_CHIP]) begin
                finish(1'b0);
              end else begin
                addr     <= `FPSC_ADDR_ZERO;
                end_addr <= `FPSC_LAST_ADDR;
                state    <= ST_ERASE;
                // Chip erase lifts the block and write prohibitions
                sec_store[`FPSC_SEC_BLOCK]  <= 1'b0;
                sec_store[`FPSC_SEC_WRITE]  <= 1'b0;
                sec_active[`FPSC_SEC_BLOCK] <= 1'b0;
                sec_active[`FPSC_SEC_WRITE] <= 1'b0;
              end
            end
            `FPSC_CMD_BLOCK: begin
              if (sec_active != `FPSC_SEC_NONE) begin
                finish(1'b0);
              end else begin
                start_block(par[3:0]);
                state <= ST_ERASE;
              end
            end
            `FPSC_CMD_WRITE: begin
              if (sec_active[`FPSC_SEC_WRITE] || range_bad) begin
                finish(1'b0);
              end else begin
                // Chip erase prohibition alone still lets writes in
                addr       <= range_lo;
                end_addr   <= range_hi;
                resp_valid <= 1'b1;
                resp_code  <= `FPSC_RESP_ACK;
                state      <= ST_WDATA;
              end
            end
            `FPSC_CMD_SUM: begin
              if (range_bad) begin
                finish(1'b0);
              end else begin
                addr     <= range_lo;
                end_addr <= range_hi;
                state    <= ST_SUM;
              end
            end
            `FPSC_CMD_BLANK: begin
              addr     <= `FPSC_ADDR_ZERO;
              end_addr <= `FPSC_LAST_ADDR;
              state    <= ST_BLANK;
            end
            `FPSC_CMD_SEC: begin
              // Only ever adds bits, so nothing can lift a prohibition here
              sec_store <= sec_store | par[2:0];
              finish(1'b1);
            end
            default: finish(1'b0);
          endcase
        end
        ST_ERASE: begin
          if (last)
            finish(1'b1);
          else
            addr <= addr + 1'b1;
        end
        ST_WDATA: begin
          if (!attach_s) begin
            state <= ST_IDLE;
          end else if (rx_valid) begin
            wbyte <= rx_data;
            state <= ST_WPROG;
          end
        end
        ST_WPROG: begin
          state <= ST_VER;
        end
        ST_VER: begin
          if (last) begin
            finish(!err && (rd_data == wbyte));
          end else begin
            if (rd_data != wbyte)
              err <= 1'b1;
            addr  <= addr + 1'b1;
            state <= ST_WDATA;
          end
        end
        ST_SUM: begin
          if (last) begin
            resp_sum <= sum + {8'h00, rd_data};
            finish(1'b1);
          end else begin
            sum  <= sum + {8'h00, rd_data};
            addr <= addr + 1'b1;
          end
        end
        ST_BLANK: begin
          if (last) begin
            finish(!err && (rd_data == `FPSC_BLANK_BYTE));
          end else begin
            if (rd_data != `FPSC_BLANK_BYTE)
              err <= 1'b1;
            addr <= addr + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== fpsc_map.vh ====
// Constants for the flash programming and security controller.
// Assumes inclusion by bare name from the design, checker and bench top files.
`ifndef FPSC_MAP_VH
`define FPSC_MAP_VH

`define FPSC_AW          12
`define FPSC_LAST_ADDR   12'hfff
`define FPSC_ADDR_ZERO   12'h000
`define FPSC_BLK_FIRST   8'h00
`define FPSC_BLK_LAST    8'hff
`define FPSC_BLANK_BYTE  8'hff

`define FPSC_CMD_CHIP    8'h20
`define FPSC_CMD_BLOCK   8'h22
`define FPSC_CMD_BLANK   8'h32
`define FPSC_CMD_WRITE   8'h40
`define FPSC_CMD_SEC     8'ha0
`define FPSC_CMD_SUM     8'hb0

`define FPSC_RESP_ACK    8'h06
`define FPSC_RESP_NAK    8'h15

`define FPSC_SELF_ERASE  2'h0
`define FPSC_SELF_BLANK  2'h1
`define FPSC_SELF_WRITE  2'h2

`define FPSC_SEC_CHIP    0
`define FPSC_SEC_BLOCK   1
`define FPSC_SEC_WRITE   2
`define FPSC_SEC_NONE    3'h0

`define FPSC_PCNT_ZERO   3'h0
`define FPSC_PCNT_ONE    3'h1
`define FPSC_PCNT_FOUR   3'h4
`define FPSC_SUM_ZERO    16'h0000
`define FPSC_PAR_ZERO    32'h00000000

`define FPSC_PORT_RST_OUT 8'h00
`define FPSC_PORT_RST_OE  8'h00

`endif

// ==== fpsc_flash.v ====
// Flash cell array of 4 KB, sixteen blocks of 256 bytes.
// Assumes one byte operation per cycle issued by the controller.
`timescale 1ns/100ps
`default_nettype none
`include "fpsc_map.vh"

module fpsc_flash (
  input  wire                    sys_clk,
  input  wire                    wr_en,
  input  wire                    erase,
  input  wire [`FPSC_AW-1:0]     addr,
  input  wire [7:0]              wr_data,
  output wire [7:0]              rd_data
);

  reg [7:0] cells [0:(1<<`FPSC_AW)-1];

  // Programming only clears bits; only erase can bring ones back
  always @(posedge sys_clk) begin
    if (wr_en) begin
      if (erase)
        cells[addr] <= `FPSC_BLANK_BYTE;
      else
        cells[addr] <= cells[addr] & wr_data;
    end
  end

  assign rd_data = cells[addr];

endmodule
`default_nettype wire

// ==== fpsc_checker.sv ====
// Port assertions for the flash programming controller.
// Assumes a bind onto fpsc_ctrl; all signals on sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "fpsc_map.vh"
module fpsc_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        rx_valid,
  input wire logic        resp_valid,
  input wire logic [7:0]  resp_code,
  input wire logic [15:0] resp_sum,
  input wire logic        prog_mode,
  input wire logic        self_mode,
  input wire logic        self_cmd_valid,
  input wire logic [1:0]  self_op,
  input wire logic        self_busy,
  input wire logic        self_done,
  input wire logic [7:0]  user_port_out,
  input wire logic [7:0]  user_port_oe,
  input wire logic [7:0]  port_out,
  input wire logic [7:0]  port_oe,
  input wire logic [2:0]  sec_active
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response pulse too long");
  a_resp_code: assert property (resp_valid |-> resp_code == `FPSC_RESP_ACK ||
    resp_code == `FPSC_RESP_NAK) else $error("bad response code");
  a_sum_update: assert property ($changed(resp_sum) |-> resp_valid)
    else $error("checksum moved without response");
  a_mode_entry: assert property ($rose(prog_mode) |-> $past(rx_valid) ||
    $past(rx_valid, 2)) else $error("mode entered without a byte");
  a_prog_pins: assert property (prog_mode && $past(prog_mode) |->
    port_out == 8'h00 && port_oe == 8'h00) else $error("pins left reset state");
  a_user_follow: assert property (!prog_mode && !self_mode && $past(rst_n) &&
    !$past(prog_mode) && !$past(self_mode) |-> port_out == $past(user_port_out) &&
    port_oe == $past(user_port_oe)) else $error("pins not following user");
  a_self_freeze: assert property (self_mode && $past(self_mode) && !prog_mode &&
    !$past(prog_mode) |-> $stable(port_out) && $stable(port_oe)) else $error("pins moved");
  a_ship_state: assert property ($rose(rst_n) |-> sec_active == 3'h0)
    else $error("prohibition active after reset");
  a_chip_lock: assert property (sec_active[0] |=> sec_active[0])
    else $error("chip lock cleared");
  a_self_write: assert property (self_cmd_valid && self_mode && !prog_mode &&
    !self_busy && self_op == `FPSC_SELF_WRITE |-> ##[1:4] self_done)
    else $error("self write never finished");
endmodule
`default_nettype wire

// ==== fpsc_prog_model.sv ====
// Programmer model: owns device reset, attach line and byte link.
// Assumes the bench calls its tasks; bytes leave just after an edge.
`timescale 1ns/100ps
`default_nettype none
module fpsc_prog_model (
  input  wire logic       sys_clk,
  output var  logic       rst_n,
  output var  logic       prog_attach,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data
);
  initial begin
    rst_n = 1'b0;
    prog_attach = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Only this model ever pulls reset
  task reset_dev;
    rst_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
  endtask
  // Extra edges let the attach synchroniser settle
  task attach(input logic v);
    @(posedge sys_clk);
    #1 prog_attach = v;
    repeat (4) @(posedge sys_clk);
    #2;
  endtask
  // Idle line shows the inverse so stale data never looks valid
  task send(input logic [7:0] b);
    @(posedge sys_clk);
    #1 rx_valid = 1'b1;
    rx_data = b;
    @(posedge sys_clk);
    #1 rx_valid = 1'b0;
    rx_data = ~b;
  endtask
endmodule
`default_nettype wire

// ==== fpsc_ctrl_tb_top.sv ====
// Bench top: reference model of flash and prohibitions against fpsc_ctrl.
// Assumes fpsc_map.vh on the include path; the programmer model drives reset.
`timescale 1ns/100ps
`default_nettype none
`include "fpsc_map.vh"
module fpsc_ctrl_tb_top;
  logic        sys_clk, rst_n, prog_attach, rx_valid, resp_valid, prog_mode, self_mode;
  logic        self_cmd_valid, self_busy, self_done, self_ok;
  logic [1:0]  self_op;
  logic [2:0]  sec_active, store, act;
  logic [7:0]  rx_data, resp_code, self_data, user_port_out, user_port_oe, port_out, port_oe;
  logic [11:0] self_addr;
  logic [15:0] resp_sum;
  logic [7:0]  mem [0:4095];
  int          error_cnt, checks_done, n_resp, n0;
  fpsc_ctrl uut (.*);
  fpsc_prog_model pm (.*);
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (resp_valid === 1'b1) n_resp++;
  always @(posedge sys_clk) begin
    #1;
    user_port_out = 8'($urandom);
    user_port_oe = 8'($urandom);
  end
  task cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task tend(input string n);
    $display("test %s done, mismatches %0d", n, error_cnt);
  endtask
  task wait_resp(input logic ok);
    int i;
    i = 0;
    // An unknown byte in programming mode answers at its own edge, so look before waiting
    while (resp_valid !== 1'b1 && i < 9000) begin
      @(posedge sys_clk);
      #2;
      i++;
    end
    if (resp_valid !== 1'b1) begin
      error_cnt++;
      finish_test;
    end
    cmp_val("resp_code", 16'(ok ? `FPSC_RESP_ACK : `FPSC_RESP_NAK), 16'(resp_code));
  endtask
  task rng(input logic [7:0] c, input logic [11:0] s, input logic [11:0] e);
    pm.send(c);
    pm.send({4'h0, s[11:8]});
    pm.send(s[7:0]);
    pm.send({4'h0, e[11:8]});
    pm.send(e[7:0]);
  endtask
  task chip;
    logic ok;
    ok = !act[0];
    if (ok) begin
      foreach (mem[i]) mem[i] = 8'hff;
      act[2:1] = 2'h0;
      store[2:1] = 2'h0;
    end
    pm.send(`FPSC_CMD_CHIP);
    wait_resp(ok);
    cmp_val("sec_active", 16'(act), 16'(sec_active));
  endtask
  task blk(input logic [3:0] b);
    logic ok;
    ok = act === 3'h0;
    if (ok) for (int a = 0; a < 256; a++) mem[{b, 8'(a)}] = 8'hff;
    pm.send(`FPSC_CMD_BLOCK);
    pm.send({4'h0, b});
    wait_resp(ok);
  endtask
  task wr(input int s, input int e, input logic [7:0] ones);
    logic ok;
    logic [7:0] d;
    rng(`FPSC_CMD_WRITE, 12'(s), 12'(e));
    wait_resp(!act[2]);
    if (!act[2]) begin
      ok = 1'b1;
      for (int a = s; a <= e; a++) begin
        d = 8'($urandom) | ones;
        ok &= (mem[a] & d) == d;
        mem[a] &= d;
        pm.send(d);
        @(posedge sys_clk);
        #1;
      end
      wait_resp(ok);
    end
  endtask
  task sum(input int s, input int e);
    logic [15:0] t;
    t = 16'h0000;
    for (int a = s; a <= e; a++) t += 16'(mem[a]);
    rng(`FPSC_CMD_SUM, 12'(s), 12'(e));
    wait_resp(1'b1);
    cmp_val("resp_sum", t, resp_sum);
  endtask
  task blank;
    logic ok;
    ok = 1'b1;
    foreach (mem[i]) ok &= mem[i] === 8'hff;
    pm.send(`FPSC_CMD_BLANK);
    wait_resp(ok);
  endtask
  task sec(input logic [2:0] f);
    store |= f;
    pm.send(`FPSC_CMD_SEC);
    pm.send({5'h00, f});
    wait_resp(1'b1);
    cmp_val("sec_active", 16'(act), 16'(sec_active));
  endtask
  task reenter;
    pm.attach(1'b0);
    cmp_val("prog_mode", 16'h0000, 16'(prog_mode));
    pm.attach(1'b1);
    act = store;
    sum(0, 511);
    cmp_val("sec_active", 16'(act), 16'(sec_active));
  endtask
  task self_run(input logic [1:0] op, input logic [11:0] a, input logic ok);
    int i;
    @(posedge sys_clk);
    #1 self_cmd_valid = 1'b1;
    self_op = op;
    self_addr = a;
    @(posedge sys_clk);
    #1 self_cmd_valid = 1'b0;
    i = 0;
    while (self_done !== 1'b1 && i < 400) begin
      @(posedge sys_clk);
      #2;
      i++;
    end
    if (self_done !== 1'b1) begin
      error_cnt++;
      finish_test;
    end
    cmp_val("self_ok", 16'(ok), 16'(self_ok));
  endtask
  initial begin
    sys_clk = 1'b0;
    {self_mode, self_cmd_valid, self_op, self_addr, self_data} = '0;
    {store, act} = '0;
    void'($urandom(32'ha7a7));
    pm.reset_dev();
    cmp_val("sec_active", 16'h0000, 16'(sec_active));
    n0 = n_resp;
    pm.send(`FPSC_CMD_CHIP);
    repeat (10) @(posedge sys_clk);
    cmp_val("resp_count", 16'(n0), 16'(n_resp));
    pm.attach(1'b1);
    chip;
    cmp_val("prog_mode", 16'h0001, 16'(prog_mode));
    cmp_val("port_oe", 16'h0000, 16'(port_oe));
    blank;
    tend("entry");
    wr(12'h0fe, 12'h103, 8'h00);
    sum(12'h0f0, 12'h10f);
    blank;
    wr(12'h100, 12'h101, 8'hff);
    blk(4'h0);
    sum(0, 511);
    tend("data");
    sec(3'h6);
    reenter;
    blk(4'h1);
    wr(12'h200, 12'h200, 8'h00);
    pm.send(8'h55);
    wait_resp(1'b0);
    chip;
    tend("block and write lock");
    sec(3'h1);
    reenter;
    chip;
    blk(4'h2);
    wr(12'h300, 12'h301, 8'h00);
    sec(3'h0);
    reenter;
    tend("chip lock");
    pm.attach(1'b0);
    @(posedge sys_clk);
    #1 self_mode = 1'b1;
    self_run(`FPSC_SELF_ERASE, 12'h100, 1'b1);
    for (int a = 256; a < 512; a++) mem[a] = 8'hff;
    self_run(2'h3, 12'h100, 1'b0);
    self_data = 8'($urandom) & 8'h7f;
    self_run(`FPSC_SELF_WRITE, 12'h1ff, 1'b1);
    mem[12'h1ff] = self_data;
    self_run(`FPSC_SELF_BLANK, 12'h100, 1'b0);
    cmp_val("sec_active", 16'(act), 16'(sec_active));
    @(posedge sys_clk);
    #1 self_mode = 1'b0;
    reenter;
    tend("self");
    finish_test;
  end
endmodule
bind fpsc_ctrl fpsc_checker chk (.*);
`default_nettype wire
